// [hw/piu_top.sv]
// Two-level prioritized interrupt unit with Avalon-MM register slave
//
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module piu_top
  import piu_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Sources
  input wire logic [7:0] periph_one_flags_i,
  input wire logic [3:0] periph_two_flags_i,
  input wire logic ext_pin_zero_i,
  input wire logic ext_pin_one_i,
  input wire logic ext_pin_two_i,
  input wire logic timer_zero_tick_i,
  input wire logic timer_zero_wide_i,
  input wire logic [3:0] port_b_high_i,
  // Core side
  input wire logic core_sleep_i,
  input wire logic core_ack_i,
  input wire logic core_return_i,
  input wire logic [20:0] core_pc_i,
  input wire logic [7:0] core_working_i,
  input wire logic [7:0] core_status_i,
  input wire logic [7:0] core_bank_i,
  output logic irq_high_o,
  output logic irq_low_o,
  output logic wake_o,
  output logic stack_push_o,
  output logic [20:0] stack_pc_o,
  output logic [7:0] fast_working_o,
  output logic [7:0] fast_status_o,
  output logic [7:0] fast_bank_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] peripheral_enable_one_reg;
  logic [3:0] peripheral_enable_two_reg;
  logic [7:0] peripheral_priority_one_reg;
  logic [3:0] peripheral_priority_two_reg;
  logic [7:0] reset_and_priority_control_reg;
  logic [7:0] main_ctl_reg;
  logic [7:0] ctl_two_reg;
  logic [7:0] ctl_three_reg;
  logic [2:0] ext_prev_reg;
  logic [3:0] port_prev_reg;
  logic [15:0] timer_zero_reg;
  logic bus_ack_reg;
  piu_state_e state_reg;

  logic wr_hit;
  logic [7:0] wdat;
  logic [2:0] ext_now;
  logic [2:0] edge_sel;
  logic [2:0] ext_edge;
  logic t0_wrap;
  logic port_change;
  logic prio_en;
  logic [7:0] req_one;
  logic [3:0] req_two;
  logic [7:0] prio_one_eff;
  logic [3:0] prio_two_eff;
  logic ext0_req;
  logic ext1_req;
  logic ext2_req;
  logic t0_req;
  logic rb_req;
  logic any_high;
  logic any_low;
  logic any_core_req;
  logic global_interrupt_enable;
  logic peripheral_global_enable;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // One wait cycle per access: waitrequest drops in the second cycle
  assign wr_hit = avs_write_i && !bus_ack_reg && avs_byteenable_i[0];
  assign wdat = avs_writedata_i[7:0];

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_ack_reg <= 1'b0;
    end else if (clk_en_i) begin
      bus_ack_reg <= (avs_read_i || avs_write_i) && !bus_ack_reg;
    end
  end

  // Waitrequest high unless acknowledging
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (clk_en_i) begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !bus_ack_reg);
    end
  end

  // Read mux, registered
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      avs_readdata_o <= PIU_UNMAPPED_READ;
    end else if (clk_en_i) begin
      if (!avs_read_i || bus_ack_reg) begin
        avs_readdata_o <= PIU_UNMAPPED_READ;
      end else if (avs_address_i == PIU_PERIPHERAL_ENABLE_ONE_OFS) begin
        avs_readdata_o <= {24'h000000, peripheral_enable_one_reg};
      end else if (avs_address_i == PIU_PERIPHERAL_ENABLE_TWO_OFS) begin
        avs_readdata_o <= {28'h0000000, peripheral_enable_two_reg};
      end else if (avs_address_i == PIU_PERIPHERAL_PRIORITY_ONE_OFS) begin
        avs_readdata_o <= {24'h000000, peripheral_priority_one_reg};
      end else if (avs_address_i == PIU_PERIPHERAL_PRIORITY_TWO_OFS) begin
        avs_readdata_o <= {28'h0000000, peripheral_priority_two_reg};
      end else if (avs_address_i == PIU_RESET_AND_PRIORITY_CONTROL_OFS) begin
        avs_readdata_o <= {24'h000000, reset_and_priority_control_reg};
      end else if (avs_address_i == PIU_MAIN_CONTROL_OFS) begin
        avs_readdata_o <= {24'h000000, main_ctl_reg};
      end else if (avs_address_i == PIU_CONTROL_TWO_OFS) begin
        avs_readdata_o <= {24'h000000, ctl_two_reg};
      end else if (avs_address_i == PIU_CONTROL_THREE_OFS) begin
        avs_readdata_o <= {24'h000000, ctl_three_reg};
      end else begin
        avs_readdata_o <= PIU_UNMAPPED_READ;
      end
    end
  end

  // ----------------------------------------------------------------
  // Enable and priority registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      peripheral_enable_one_reg <= PIU_ENABLE_ONE_RST;
      peripheral_enable_two_reg <= PIU_ENABLE_TWO_RST;
      peripheral_priority_one_reg <= PIU_PRIORITY_ONE_RST;
      peripheral_priority_two_reg <= PIU_PRIORITY_TWO_RST;
    end else if (clk_en_i && wr_hit) begin
      if (avs_address_i == PIU_PERIPHERAL_ENABLE_ONE_OFS) begin
        peripheral_enable_one_reg <= wdat;
      end else if (avs_address_i == PIU_PERIPHERAL_ENABLE_TWO_OFS) begin
        peripheral_enable_two_reg <= wdat[3:0];
      end else if (avs_address_i == PIU_PERIPHERAL_PRIORITY_ONE_OFS) begin
        peripheral_priority_one_reg <= wdat;
      end else if (avs_address_i == PIU_PERIPHERAL_PRIORITY_TWO_OFS) begin
        peripheral_priority_two_reg <= wdat[3:0];
      end
    end
  end

  // Reset and priority control; watchdog and power-down flags are read-only here, the reset instruction flag is writable
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reset_and_priority_control_reg <= PIU_RESET_AND_PRIORITY_CONTROL_RST;
    end else if (clk_en_i && wr_hit &&
                 avs_address_i == PIU_RESET_AND_PRIORITY_CONTROL_OFS) begin
      reset_and_priority_control_reg <= (reset_and_priority_control_reg & ~PIU_RESET_AND_PRIORITY_CONTROL_WMASK) | (wdat & PIU_RESET_AND_PRIORITY_CONTROL_WMASK);
    end
  end

  // Control two: edge selects and priorities
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctl_two_reg <= PIU_CTL2_RST;
    end else if (clk_en_i && wr_hit &&
                 avs_address_i == PIU_CONTROL_TWO_OFS) begin
      ctl_two_reg <= wdat & PIU_CTL2_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  assign ext_now = {ext_pin_two_i, ext_pin_one_i, ext_pin_zero_i};
  assign edge_sel = {ctl_two_reg[PIU_EXT_EDGE_SELECT_TWO_BIT],
                     ctl_two_reg[PIU_EXT_EDGE_SELECT_ONE_BIT],
                     ctl_two_reg[PIU_EXT_EDGE_SELECT_ZERO_BIT]};
  // Rising when select set, falling when clear
  assign ext_edge = (edge_sel & ext_now & ~ext_prev_reg) |
                    (~edge_sel & ~ext_now & ext_prev_reg);
  assign t0_wrap = timer_zero_tick_i &&
                   (timer_zero_wide_i ? (timer_zero_reg == 16'hFFFF)
                                      : (timer_zero_reg[7:0] == 8'hFF));
  assign port_change = port_b_high_i != port_prev_reg;

  // Previous pin levels
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_prev_reg <= 3'h0;
      port_prev_reg <= 4'h0;
    end else if (clk_en_i) begin
      ext_prev_reg <= ext_now;
      port_prev_reg <= port_b_high_i;
    end
  end

  // Timer zero count; 8-bit mode keeps the high byte at zero
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_zero_reg <= 16'h0000;
    end else if (clk_en_i && timer_zero_tick_i) begin
      if (timer_zero_wide_i) begin
        timer_zero_reg <= timer_zero_reg + 16'h0001;
      end else begin
        timer_zero_reg <= {8'h00, timer_zero_reg[7:0] + 8'h01};
      end
    end
  end

  // ----------------------------------------------------------------
  // Main control: enables and flags; set beats software clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      main_ctl_reg <= PIU_MAIN_RST;
    end else if (clk_en_i) begin
      if (wr_hit && avs_address_i == PIU_MAIN_CONTROL_OFS) begin
        main_ctl_reg <= wdat;
      end
      // Flags set regardless of enables; set wins
      if (t0_wrap) begin
        main_ctl_reg[PIU_TIMER_ZERO_OVERFLOW_FLAG_BIT] <= 1'b1;
      end
      if (ext_edge[0]) begin
        main_ctl_reg[PIU_EXT_ZERO_FLAG_BIT] <= 1'b1;
      end
      if (port_change) begin
        main_ctl_reg[PIU_PORT_CHANGE_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // Control three: external one/two enables, flags and priorities
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctl_three_reg <= PIU_CTL3_RST;
    end else if (clk_en_i) begin
      if (wr_hit && avs_address_i == PIU_CONTROL_THREE_OFS) begin
        ctl_three_reg <= wdat & PIU_CTL3_WMASK;
      end
      // Flag stays set until software clears it
      if (ext_edge[1]) begin
        ctl_three_reg[PIU_EXT_ONE_FLAG_BIT] <= 1'b1;
      end
      if (ext_edge[2]) begin
        ctl_three_reg[PIU_EXT_TWO_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Request routing
  // ----------------------------------------------------------------
  assign prio_en = reset_and_priority_control_reg[PIU_PRIORITY_LEVELS_ENABLE_BIT];
  assign global_interrupt_enable = main_ctl_reg[PIU_GLOBAL_INTERRUPT_ENABLE_BIT];
  assign peripheral_global_enable = main_ctl_reg[PIU_PERIPHERAL_GLOBAL_ENABLE_BIT];
  assign req_one = periph_one_flags_i & peripheral_enable_one_reg;
  assign req_two = periph_two_flags_i & peripheral_enable_two_reg;
  // Priorities forced high in legacy single-level mode
  assign prio_one_eff = prio_en ? peripheral_priority_one_reg : 8'hFF;
  assign prio_two_eff = prio_en ? peripheral_priority_two_reg : 4'hF;
  assign ext0_req = main_ctl_reg[PIU_EXT_ZERO_FLAG_BIT] &&
                    main_ctl_reg[PIU_EXT_ZERO_ENABLE_BIT];
  assign ext1_req = ctl_three_reg[PIU_EXT_ONE_FLAG_BIT] &&
                    ctl_three_reg[PIU_EXT_ONE_ENABLE_BIT];
  assign ext2_req = ctl_three_reg[PIU_EXT_TWO_FLAG_BIT] &&
                    ctl_three_reg[PIU_EXT_TWO_ENABLE_BIT];
  assign t0_req = main_ctl_reg[PIU_TIMER_ZERO_OVERFLOW_FLAG_BIT] &&
                  main_ctl_reg[PIU_TIMER_ZERO_ENABLE_BIT];
  assign rb_req = main_ctl_reg[PIU_PORT_CHANGE_FLAG_BIT] &&
                  main_ctl_reg[PIU_PORT_CHANGE_ENABLE_BIT];

  // High level: external zero is always high
  always_comb begin
    any_high = ext0_req;
    any_high = any_high || (ext1_req &&
               (!prio_en || ctl_three_reg[PIU_EXT_ONE_PRIORITY_BIT]));
    any_high = any_high || (ext2_req &&
               (!prio_en || ctl_three_reg[PIU_EXT_TWO_PRIORITY_BIT]));
    any_high = any_high || (t0_req &&
               (!prio_en || ctl_two_reg[PIU_TIMER_ZERO_PRIORITY_BIT]));
    any_high = any_high || (rb_req &&
               (!prio_en || ctl_two_reg[PIU_PORT_CHANGE_PRIORITY_BIT]));
    // Legacy mode: peripherals also need their global enable
    any_high = any_high || ((prio_en || peripheral_global_enable) &&
               (|(req_one & prio_one_eff) || |(req_two & prio_two_eff)));
  end

  // Low level only exists with levels enabled
  always_comb begin
    any_low = 1'b0;
    if (prio_en) begin
      any_low = (ext1_req && !ctl_three_reg[PIU_EXT_ONE_PRIORITY_BIT]) ||
                (ext2_req && !ctl_three_reg[PIU_EXT_TWO_PRIORITY_BIT]) ||
                (t0_req && !ctl_two_reg[PIU_TIMER_ZERO_PRIORITY_BIT]) ||
                (rb_req && !ctl_two_reg[PIU_PORT_CHANGE_PRIORITY_BIT]) ||
                |(req_one & ~prio_one_eff) ||
                |(req_two & ~prio_two_eff);
    end
  end

  assign any_core_req = any_high || any_low;

  // Wake on any enabled request while asleep
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wake_o <= 1'b0;
    end else if (clk_en_i) begin
      wake_o <= core_sleep_i && any_core_req;
    end
  end

  // ----------------------------------------------------------------
  // Core handshake: request, entry, return
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= PIU_IDLE;
    end else if (clk_en_i) begin
      case (state_reg)
        PIU_IDLE: begin
          if (core_ack_i && irq_high_o) begin
            state_reg <= PIU_IN_HIGH;
          end else if (core_ack_i && irq_low_o) begin
            state_reg <= PIU_IN_LOW;
          end
        end
        PIU_IN_LOW: begin
          if (core_return_i) begin
            state_reg <= PIU_IDLE;
          end else if (core_ack_i && irq_high_o) begin
            state_reg <= PIU_IN_HIGH;
          end
        end
        PIU_IN_HIGH: begin
          if (core_return_i) begin
            state_reg <= PIU_IDLE;
          end
        end
        default: begin
          state_reg <= PIU_IDLE;
        end
      endcase
    end
  end

  // Requests to core, gated by global enable and nesting level
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_high_o <= 1'b0;
      irq_low_o <= 1'b0;
    end else if (clk_en_i) begin
      irq_high_o <= global_interrupt_enable && any_high && state_reg != PIU_IN_HIGH;
      irq_low_o <= global_interrupt_enable && any_low && !any_high && state_reg == PIU_IDLE;
    end
  end

  // Entry push of return counter and fast context
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stack_push_o <= 1'b0;
      stack_pc_o <= 21'h00000;
      fast_working_o <= 8'h00;
      fast_status_o <= 8'h00;
      fast_bank_o <= 8'h00;
    end else if (clk_en_i) begin
      stack_push_o <= core_ack_i && (irq_high_o || irq_low_o);
      if (core_ack_i && (irq_high_o || irq_low_o)) begin
        stack_pc_o <= core_pc_i;
        fast_working_o <= core_working_i;
        fast_status_o <= core_status_i;
        fast_bank_o <= core_bank_i;
      end
    end
  end

endmodule : piu_top

// [hw/piu_pkg.sv]
// Package: register map, field positions and reset values of the interrupt unit
package piu_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] PIU_PERIPHERAL_ENABLE_ONE_OFS = 5'h00;
  localparam logic [4:0] PIU_PERIPHERAL_ENABLE_TWO_OFS = 5'h04;
  localparam logic [4:0] PIU_PERIPHERAL_PRIORITY_ONE_OFS = 5'h08;
  localparam logic [4:0] PIU_PERIPHERAL_PRIORITY_TWO_OFS = 5'h0C;
  localparam logic [4:0] PIU_RESET_AND_PRIORITY_CONTROL_OFS = 5'h10;
  localparam logic [4:0] PIU_MAIN_CONTROL_OFS = 5'h14;
  localparam logic [4:0] PIU_CONTROL_TWO_OFS = 5'h18;
  localparam logic [4:0] PIU_CONTROL_THREE_OFS = 5'h1C;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PIU_ENABLE_ONE_RST = 8'h00;
  localparam logic [3:0] PIU_ENABLE_TWO_RST = 4'h0;
  localparam logic [7:0] PIU_PRIORITY_ONE_RST = 8'hFF;
  localparam logic [3:0] PIU_PRIORITY_TWO_RST = 4'hF;
  localparam logic [7:0] PIU_RESET_AND_PRIORITY_CONTROL_RST = 8'h1C;
  localparam logic [7:0] PIU_MAIN_RST = 8'h00;
  localparam logic [7:0] PIU_CTL2_RST = 8'h75;
  localparam logic [7:0] PIU_CTL3_RST = 8'hC0;

  // ----------------------------------------------------------------
  // Writable masks (reserved and read-only bits stay put)
  // ----------------------------------------------------------------
  localparam logic [7:0] PIU_RESET_AND_PRIORITY_CONTROL_WMASK = 8'hD3;
  localparam logic [7:0] PIU_CTL2_WMASK = 8'h75;
  localparam logic [7:0] PIU_CTL3_WMASK = 8'hDB;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // Reset and priority control
  localparam int PIU_PRIORITY_LEVELS_ENABLE_BIT = 7;
  localparam int PIU_RESET_INSTRUCTION_FLAG_BIT = 4;
  localparam int PIU_WATCHDOG_TIMEOUT_FLAG_BIT = 3;
  localparam int PIU_POWER_DOWN_FLAG_BIT = 2;
  // Main control
  localparam int PIU_GLOBAL_INTERRUPT_ENABLE_BIT = 7;
  localparam int PIU_PERIPHERAL_GLOBAL_ENABLE_BIT = 6;
  localparam int PIU_TIMER_ZERO_ENABLE_BIT = 5;
  localparam int PIU_EXT_ZERO_ENABLE_BIT = 4;
  localparam int PIU_PORT_CHANGE_ENABLE_BIT = 3;
  localparam int PIU_TIMER_ZERO_OVERFLOW_FLAG_BIT = 2;
  localparam int PIU_EXT_ZERO_FLAG_BIT = 1;
  localparam int PIU_PORT_CHANGE_FLAG_BIT = 0;
  // Control two
  localparam int PIU_EXT_EDGE_SELECT_ZERO_BIT = 6;
  localparam int PIU_EXT_EDGE_SELECT_ONE_BIT = 5;
  localparam int PIU_EXT_EDGE_SELECT_TWO_BIT = 4;
  localparam int PIU_TIMER_ZERO_PRIORITY_BIT = 2;
  localparam int PIU_PORT_CHANGE_PRIORITY_BIT = 0;
  // Control three
  localparam int PIU_EXT_TWO_PRIORITY_BIT = 7;
  localparam int PIU_EXT_ONE_PRIORITY_BIT = 6;
  localparam int PIU_EXT_TWO_ENABLE_BIT = 4;
  localparam int PIU_EXT_ONE_ENABLE_BIT = 3;
  localparam int PIU_EXT_TWO_FLAG_BIT = 1;
  localparam int PIU_EXT_ONE_FLAG_BIT = 0;

  // Read data for unmapped addresses and for cycles that answer no read
  localparam logic [31:0] PIU_UNMAPPED_READ = 32'h0000_0000;

  // Core handshake states (Gray along idle, high, low)
  typedef enum logic [1:0] {
    PIU_IDLE = 2'b00,
    PIU_IN_HIGH = 2'b01,
    PIU_IN_LOW = 2'b11
  } piu_state_e;

endpackage : piu_pkg

// [dv/piu_top_monitor.sv]
// Port checker for the prioritized interrupt unit
`timescale 1ns/1ps
module piu_top_monitor (
  input wire logic clk_i, rst_b_i, clk_en_i, avs_read_i, avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o, core_sleep_i, core_ack_i,
  input wire logic [20:0] core_pc_i, stack_pc_o,
  input wire logic [7:0] core_working_i, core_status_i, core_bank_i,
  input wire logic [7:0] fast_working_o, fast_status_o, fast_bank_o,
  input wire logic irq_high_o, irq_low_o, wake_o, stack_push_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Bus answer timing and idle read data
  a_bus_one_wait: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o && clk_en_i
    |=> !avs_waitrequest_o) else $error("bus answer late");
  a_ack_one_cycle: assert property (
    !avs_waitrequest_o |=> avs_waitrequest_o) else $error("ack too long");
  a_idle_rdata: assert property (
    avs_waitrequest_o |-> avs_readdata_o == 32'h0) else $error("rdata");
  // Entry pushes the counter and saves context from the ack cycle
  a_push_follows: assert property (
    core_ack_i && (irq_high_o || irq_low_o) && clk_en_i |=> stack_push_o
    ##1 !stack_push_o) else $error("push missing");
  a_context_saved: assert property (
    core_ack_i && (irq_high_o || irq_low_o) && clk_en_i |=>
    stack_pc_o == $past(core_pc_i) && fast_working_o == $past(core_working_i)
    && fast_status_o == $past(core_status_i)
    && fast_bank_o == $past(core_bank_i)) else $error("context wrong");
  a_push_cause: assert property (
    stack_push_o |-> $past(core_ack_i) && $past(irq_high_o || irq_low_o))
    else $error("push without ack");
  // Requests: wake only asleep, never both levels at once
  a_wake_sleep: assert property (
    wake_o |-> $past(core_sleep_i)) else $error("wake while awake");
  a_level_excl: assert property (
    !(irq_high_o && irq_low_o)) else $error("both levels high");
  a_ack_drops_irq: assert property (
    core_ack_i && irq_high_o && clk_en_i |=> ##1 !irq_high_o)
    else $error("request stays after entry");
endmodule : piu_top_monitor

bind piu_top piu_top_monitor i_mon (.clk_i, .rst_b_i, .clk_en_i,
  .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o,
  .core_sleep_i, .core_ack_i, .core_pc_i, .stack_pc_o, .core_working_i,
  .core_status_i, .core_bank_i, .fast_working_o, .fast_status_o,
  .fast_bank_o, .irq_high_o, .irq_low_o, .wake_o, .stack_push_o);

// [dv/piu_core_model.sv]
// Behavioural processor core answering interrupt requests
`timescale 1ns/1ps
module piu_core_model (
  input wire logic clk_i, rst_b_i, irq_high_i, irq_low_i,
  input wire logic [3:0] delay_i,
  output logic ack_o, ret_o,
  output logic [20:0] pc_o,
  output logic [7:0] working_o, status_o, bank_o
);
  logic [3:0] wait_reg;
  logic [5:0] busy_reg;
  // Counter, working and status move every cycle, bank every 256, so a stale save shows up
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pc_o <= 21'h0;
    end else begin
      pc_o <= pc_o + 21'h1;
    end
  end
  assign working_o = pc_o[7:0];
  assign status_o = ~pc_o[7:0];
  assign bank_o = pc_o[15:8];
  // Vector taken delay_i cycles into a request; F never takes it
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_reg <= 4'h0;
      ack_o <= 1'b0;
    end else if (ack_o || !(irq_high_i || irq_low_i) || delay_i == 4'hF) begin
      wait_reg <= 4'h0;
      ack_o <= 1'b0;
    end else if (wait_reg == delay_i) begin
      ack_o <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
  // Short handler: return six cycles after entry
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_reg <= 6'h00;
    end else begin
      busy_reg <= {busy_reg[4:0], ack_o};
    end
  end
  assign ret_o = busy_reg[5];
endmodule : piu_core_model

// [dv/piu_top_test.sv]
// Self-checking bench for the prioritized interrupt unit
`timescale 1ns/1ps
module piu_top_test
  import piu_pkg::*;
;
  localparam logic [4:0] MC = PIU_MAIN_CONTROL_OFS;
  localparam logic [4:0] C2 = PIU_CONTROL_TWO_OFS;
  localparam logic [4:0] C3 = PIU_CONTROL_THREE_OFS;
  logic clk_i = 1'b0, rst_b_i = 1'b0, rd = 1'b0, wr = 1'b0, slp = 1'b0;
  logic e0 = 1'b0, e1 = 1'b0, e2 = 1'b0, tk = 1'b0, wide = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [3:0] be = 4'hF, pb = 4'h0, p2 = 4'h0, dly = 4'hF;
  logic [7:0] p1 = 8'h00, cw, cs, cb, fw, fs, fb;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [20:0] pc, spc;
  logic wt, ack, ret, ih, il, wk, push;
  int errors = 0;
  int checked = 0;
  // Core clock
  always #4 clk_i = ~clk_i;
  // Device, core model
  piu_top i_dut (.clk_i, .rst_b_i, .clk_en_i(1'b1), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
    .periph_one_flags_i(p1), .periph_two_flags_i(p2), .ext_pin_zero_i(e0),
    .ext_pin_one_i(e1), .ext_pin_two_i(e2), .timer_zero_tick_i(tk),
    .timer_zero_wide_i(wide), .port_b_high_i(pb), .core_sleep_i(slp),
    .core_ack_i(ack), .core_return_i(ret), .core_pc_i(pc),
    .core_working_i(cw), .core_status_i(cs), .core_bank_i(cb),
    .irq_high_o(ih), .irq_low_o(il), .wake_o(wk), .stack_push_o(push),
    .stack_pc_o(spc), .fast_working_o(fw), .fast_status_o(fs),
    .fast_bank_o(fb));
  piu_core_model i_core (.clk_i, .rst_b_i, .irq_high_i(ih), .irq_low_i(il),
    .delay_i(dly), .ack_o(ack), .ret_o(ret), .pc_o(pc), .working_o(cw),
    .status_o(cs), .bank_o(cb));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  // One bus access; held until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= {24'h0, d};
    @(posedge clk_i);
    while (wt !== 1'b0) begin
      @(posedge clk_i);
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_i);
  endtask : xfer
  task automatic wb(input logic [4:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wb
  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(q, {24'h0, e});
  endtask : rchk
  // Reset values, writable bits, ignored and unmapped accesses
  task automatic t_regs;
    logic [39:0] r0, r1, r2;
    r0 = 40'h0000FF0F1C;
    r1 = 40'hFF0FFF0FDF;
    r2 = 40'h000000000C;
    for (int i = 0; i < 5; i++) begin
      rchk(5'(4 * i), r0[39 - 8 * i -: 8]);
      wb(5'(4 * i), 8'hFF);
      rchk(5'(4 * i), r1[39 - 8 * i -: 8]);
      wb(5'(4 * i), 8'h00);
      rchk(5'(4 * i), r2[39 - 8 * i -: 8]);
    end
    be <= 4'h0;
    wb(5'h00, 8'hFF);
    be <= 4'hF;
    rchk(5'h00, 8'h00);
    rchk(5'h02, 8'h00);
  endtask : t_regs
  // Single level needs peripheral enable; levels follow priority bits
  task automatic t_legacy;
    p1 <= 8'h01;
    wb(5'h00, 8'h01);
    wb(MC, 8'h80);
    chk(32'({ih, il}), 32'h0);
    wb(MC, 8'hC0);
    chk(32'({ih, il}), 32'h2);
    wb(5'h10, 8'h80);
    chk(32'({ih, il}), 32'h1);
    wb(5'h08, 8'h01);
    chk(32'({ih, il}), 32'h2);
    p1 <= 8'h00;
    p2 <= 4'h8;
    wb(5'h04, 8'h08);
    chk(32'({ih, il}), 32'h1);
    p2 <= 4'h0;
    wb(5'h04, 8'h00);
    wb(5'h00, 8'h00);
  endtask : t_legacy
  // External pins: edges, flags, enables, priorities
  task automatic t_ext;
    wb(MC, 8'hD0);
    e0 <= 1'b1;
    cyc(4);
    chk(32'({ih, il}), 32'h2);
    rchk(MC, 8'hD2);
    wb(MC, 8'hD0);
    wb(C2, 8'h35);
    e0 <= 1'b0;
    cyc(4);
    rchk(MC, 8'hD2);
    wb(MC, 8'hC0);
    wb(C3, 8'h08);
    e1 <= 1'b1;
    cyc(4);
    chk(32'({ih, il}), 32'h1);
    wb(C3, 8'h49);
    chk(32'({ih, il}), 32'h2);
    wb(C3, 8'h00);
    e2 <= 1'b1;
    cyc(4);
    rchk(C3, 8'h02);
    chk(32'({ih, il}), 32'h0);
    wb(C3, 8'h00);
  endtask : t_ext
  // Timer zero: 8-bit wrap at low priority, then 16-bit wrap
  task automatic t_timer;
    wb(MC, 8'hE0);
    wb(C2, 8'h31);
    tk <= 1'b1;
    cyc(255);
    tk <= 1'b0;
    rchk(MC, 8'hE0);
    tk <= 1'b1;
    cyc(1);
    tk <= 1'b0;
    cyc(3);
    chk(32'({ih, il}), 32'h1);
    rchk(MC, 8'hE4);
    wb(MC, 8'hC0);
    wide <= 1'b1;
    tk <= 1'b1;
    cyc(65535);
    tk <= 1'b0;
    rchk(MC, 8'hC0);
    tk <= 1'b1;
    cyc(1);
    tk <= 1'b0;
    rchk(MC, 8'hC4);
    wide <= 1'b0;
    wb(MC, 8'hC0);
  endtask : t_timer
  // Port change raises high level; core enters and pushes its return counter
  task automatic t_port;
    int n;
    n = 0;
    wb(MC, 8'hC8);
    pb <= 4'h8;
    cyc(4);
    chk(32'({ih, il}), 32'h2);
    rchk(MC, 8'hC9);
    dly <= 4'h2;
    while (push !== 1'b1 && n < 12) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(push), 32'h1);
    chk(32'(spc), 32'(pc - 21'h1));
    dly <= 4'hF;
    wb(MC, 8'h00);
  endtask : t_port
  // Enabled pin wakes a sleeping core without global enable
  task automatic t_sleep;
    wb(C2, 8'h71);
    wb(MC, 8'h10);
    slp <= 1'b1;
    e0 <= 1'b1;
    cyc(4);
    chk(32'({wk, ih}), 32'h2);
    slp <= 1'b0;
    wb(MC, 8'h00);
  endtask : t_sleep
  // Counts, verdict, end of run
  task automatic print_verdict;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    t_regs();
    t_legacy();
    t_ext();
    t_timer();
    t_port();
    t_sleep();
    print_verdict();
  end
  // Watchdog
  initial begin
    #700us;
    errors++;
    print_verdict();
  end
endmodule : piu_top_test
